// ==== design/spc_pkg.sv ====
// package: offsets, field positions, reset values and carriers for the config byte bank
package spc_pkg;
  localparam logic [7:0] off_rsvd_a = 8'h07;
  localparam logic [7:0] off_xcvr_ctl_one = 8'h08;
  localparam logic [7:0] off_xcvr_ctl_two = 8'h09;
  localparam logic [7:0] off_xcvr_ver_one = 8'h0a;
  localparam logic [7:0] off_xcvr_ver_two = 8'h0b;
  localparam logic [7:0] off_test_one = 8'h0c;
  localparam logic [7:0] off_test_two = 8'h0d;
  localparam logic [7:0] off_port0_vlan = 8'h0e;
  localparam logic [7:0] off_flow_ctl = 8'h04;
  localparam logic [4:0] mreg_switch = 5'h12;
  localparam logic [4:0] mreg_vlan0 = 5'h13;
  localparam int bit_savepw = 1;
  localparam int bit_mdix = 0;
  localparam int bit_downgrade = 4;
  localparam int bit_cos = 6;
  localparam int bit_hiport = 5;
  localparam int bit_pause = 7;
  localparam int mbit_downgrade = 6;
  localparam int mbit_pause = 13;
  localparam int mbit_cos = 14;
  localparam int mbit_hiport = 13;
  localparam logic rst_savepw = 1'b1;
  localparam logic rst_mdix = 1'b1;
  localparam logic rst_downgrade = 1'b0;
  localparam logic rst_cos = 1'b0;
  localparam logic rst_hiport = 1'b0;
  localparam logic rst_pause = 1'b1;
  localparam logic [7:0] rst_rsvd_d = 8'h04;
  localparam logic [7:0] rsvd_zero = 8'h00;
  localparam logic [7:0] wake_lead = 8'h04;

  typedef struct packed {
    logic savepw;
    logic mdix;
    logic downgrade;
    logic cos;
    logic hiport;
    logic pause;
  } spc_cfg_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wake = 2'b01,
    st_flp = 2'b10
  } spc_state_type;

  typedef struct packed {
    spc_cfg_type cfg;
    spc_state_type st;
    logic [7:0] wcnt;
    logic wake;
    logic flp_go;
    logic adv_full;
    logic pause_on;
    logic hi_pri;
    logic hi_vld;
    logic [7:0] rdata;
    logic [15:0] mrdata;
  } spc_state_bundle_type;
endpackage

// ==== design/spc_config_bank.sv ====
// config byte bank 07h..0eh and 04h with management mirrors and the logic they steer
`timescale 1ns/1ps
`default_nettype none
module spc_config_bank #(
  parameter logic [7:0] wake_cycles = spc_pkg::wake_lead
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rom_we,
  input wire logic [7:0] rom_addr,
  input wire logic [7:0] rom_wdata,
  input wire logic rom_re,
  output logic [7:0] rom_rdata,
  input wire logic mgmt_we,
  input wire logic mgmt_re,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic flp_req,
  output logic xcvr_wake,
  output logic flp_start,
  output logic mdix_en,
  input wire logic link_full,
  input wire logic partner_full,
  input wire logic partner_pause,
  output logic adv_full_duplex,
  output logic pause_en,
  input wire logic rx_valid,
  input wire logic rx_tag_high,
  output logic rx_high_pri,
  output logic rx_pri_valid
);
  spc_pkg::spc_state_bundle_type s_q, s_d;

  if (wake_cycles == 8'h00) begin : g_bad_wake
    $error("wake_cycles must be at least one");
  end

  always_comb begin
    s_d = s_q;
    s_d.flp_go = 1'b0;
    s_d.hi_vld = 1'b0;
    if (rom_we) begin
      case (rom_addr)
        spc_pkg::off_xcvr_ctl_two: begin
          s_d.cfg.savepw = rom_wdata[spc_pkg::bit_savepw];
          s_d.cfg.mdix = rom_wdata[spc_pkg::bit_mdix];
        end
        spc_pkg::off_xcvr_ver_two: begin
          s_d.cfg.downgrade = rom_wdata[spc_pkg::bit_downgrade];
        end
        spc_pkg::off_port0_vlan: begin
          s_d.cfg.cos = rom_wdata[spc_pkg::bit_cos];
          s_d.cfg.hiport = rom_wdata[spc_pkg::bit_hiport];
        end
        spc_pkg::off_flow_ctl: begin
          s_d.cfg.pause = rom_wdata[spc_pkg::bit_pause];
        end
        default: begin
        end
      endcase
    end
    if (mgmt_we) begin
      case (mgmt_addr)
        spc_pkg::mreg_switch: begin
          s_d.cfg.downgrade = mgmt_wdata[spc_pkg::mbit_downgrade];
          s_d.cfg.pause = mgmt_wdata[spc_pkg::mbit_pause];
        end
        spc_pkg::mreg_vlan0: begin
          s_d.cfg.cos = mgmt_wdata[spc_pkg::mbit_cos];
          s_d.cfg.hiport = mgmt_wdata[spc_pkg::mbit_hiport];
        end
        default: begin
        end
      endcase
    end
    if (rom_re) begin
      s_d.rdata = spc_pkg::rsvd_zero;
      case (rom_addr)
        spc_pkg::off_xcvr_ctl_two: begin
          s_d.rdata[spc_pkg::bit_savepw] = s_q.cfg.savepw;
          s_d.rdata[spc_pkg::bit_mdix] = s_q.cfg.mdix;
        end
        spc_pkg::off_xcvr_ver_two: begin
          s_d.rdata[spc_pkg::bit_downgrade] = s_q.cfg.downgrade;
        end
        spc_pkg::off_test_two: begin
          s_d.rdata = spc_pkg::rst_rsvd_d;
        end
        spc_pkg::off_port0_vlan: begin
          s_d.rdata[spc_pkg::bit_cos] = s_q.cfg.cos;
          s_d.rdata[spc_pkg::bit_hiport] = s_q.cfg.hiport;
        end
        spc_pkg::off_flow_ctl: begin
          s_d.rdata[spc_pkg::bit_pause] = s_q.cfg.pause;
        end
        default: begin
        end
      endcase
    end
    if (mgmt_re) begin
      s_d.mrdata = 16'h0000;
      case (mgmt_addr)
        spc_pkg::mreg_switch: begin
          s_d.mrdata[spc_pkg::mbit_downgrade] = s_q.cfg.downgrade;
          s_d.mrdata[spc_pkg::mbit_pause] = s_q.cfg.pause;
        end
        spc_pkg::mreg_vlan0: begin
          s_d.mrdata[spc_pkg::mbit_cos] = s_q.cfg.cos;
          s_d.mrdata[spc_pkg::mbit_hiport] = s_q.cfg.hiport;
        end
        default: begin
        end
      endcase
    end
    case (s_q.st)
      spc_pkg::st_idle: begin
        s_d.wake = 1'b0;
        if (flp_req) begin
          if (s_q.cfg.savepw) begin
            s_d.st = spc_pkg::st_wake;
            s_d.wake = 1'b1;
            s_d.wcnt = wake_cycles;
          end else begin
            s_d.st = spc_pkg::st_flp;
          end
        end
      end
      spc_pkg::st_wake: begin
        s_d.wcnt = s_q.wcnt - 8'h01;
        if (s_q.wcnt == 8'h01) begin
          s_d.st = spc_pkg::st_flp;
        end
      end
      spc_pkg::st_flp: begin
        s_d.flp_go = 1'b1;
        s_d.st = spc_pkg::st_idle;
      end
      default: begin
        s_d.st = spc_pkg::st_idle;
      end
    endcase
    s_d.pause_on = s_q.cfg.pause & link_full;
    s_d.adv_full = ~(s_q.cfg.downgrade & link_full & partner_full & ~partner_pause);
    if (rx_valid) begin
      s_d.hi_vld = 1'b1;
      s_d.hi_pri = s_q.cfg.hiport | (s_q.cfg.cos & rx_tag_high);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.cfg.savepw <= spc_pkg::rst_savepw;
      s_q.cfg.mdix <= spc_pkg::rst_mdix;
      s_q.cfg.downgrade <= spc_pkg::rst_downgrade;
      s_q.cfg.cos <= spc_pkg::rst_cos;
      s_q.cfg.hiport <= spc_pkg::rst_hiport;
      s_q.cfg.pause <= spc_pkg::rst_pause;
      s_q.st <= spc_pkg::st_idle;
      s_q.adv_full <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rom_rdata = s_q.rdata;
  assign mgmt_rdata = s_q.mrdata;
  assign xcvr_wake = s_q.wake;
  assign flp_start = s_q.flp_go;
  assign mdix_en = s_q.cfg.mdix;
  assign adv_full_duplex = s_q.adv_full;
  assign pause_en = s_q.pause_on;
  assign rx_high_pri = s_q.hi_pri;
  assign rx_pri_valid = s_q.hi_vld;

  property p_wake_before_flp;
    @(posedge mclk) disable iff (rst)
      (ce && flp_start && s_q.cfg.savepw) |-> xcvr_wake;
  endproperty
  a_wake_before_flp: assert property (p_wake_before_flp) else $error("burst without wake");

  sequence s_req_idle;
    ce && flp_req && s_q.st == spc_pkg::st_idle && !s_q.cfg.savepw;
  endsequence
  property p_flp_no_wake;
    @(posedge mclk) disable iff (rst)
      s_req_idle ##1 ce |=> flp_start;
  endproperty
  a_flp_no_wake: assert property (p_flp_no_wake) else $error("burst missing");

  property p_mdix_kept;
    @(posedge mclk) disable iff (rst)
      !(ce && rom_we && rom_addr == spc_pkg::off_xcvr_ctl_two) |=> mdix_en == $past(mdix_en);
  endproperty
  a_mdix_kept: assert property (p_mdix_kept) else $error("crossover changed");

  property p_downgrade;
    @(posedge mclk) disable iff (rst)
      (ce && s_q.cfg.downgrade && link_full && partner_full && !partner_pause) |=> !adv_full_duplex;
  endproperty
  a_downgrade: assert property (p_downgrade) else $error("no downgrade");

  property p_no_downgrade;
    @(posedge mclk) disable iff (rst)
      (ce && !s_q.cfg.downgrade) |=> adv_full_duplex;
  endproperty
  a_no_downgrade: assert property (p_no_downgrade) else $error("spurious downgrade");

  property p_cos_tag;
    @(posedge mclk) disable iff (rst)
      (ce && rx_valid && s_q.cfg.cos && rx_tag_high) |=> rx_high_pri && rx_pri_valid;
  endproperty
  a_cos_tag: assert property (p_cos_tag) else $error("tagged frame not high");

  property p_hiport;
    @(posedge mclk) disable iff (rst)
      (ce && rx_valid && s_q.cfg.hiport) |=> rx_high_pri;
  endproperty
  a_hiport: assert property (p_hiport) else $error("port frame not high");

  property p_pause_gate;
    @(posedge mclk) disable iff (rst)
      (ce && !s_q.cfg.pause) |=> !pause_en;
  endproperty
  a_pause_gate: assert property (p_pause_gate) else $error("pause while disabled");

  property p_shared;
    @(posedge mclk) disable iff (rst)
      (ce && mgmt_we && mgmt_addr == spc_pkg::mreg_vlan0) |=>
        s_q.cfg.cos == $past(mgmt_wdata[spc_pkg::mbit_cos]);
  endproperty
  a_shared: assert property (p_shared) else $error("mirror mismatch");
endmodule
`default_nettype wire

// ==== testbench/spc_rom_model.sv ====
// configuration eeprom model: loads bytes through the byte write path
`timescale 1ns/1ps
`default_nettype none
module spc_rom_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] raddr,
  output logic busy,
  output logic rom_we,
  output logic [7:0] rom_addr,
  output logic [7:0] rom_wdata
);
  logic [7:0] tbl_a [3] = '{8'h09, 8'h0b, 8'h0e};
  logic [7:0] tbl_d [3] = '{8'h03, 8'h10, 8'h60};
  int idx = 3;
  assign busy = idx < 3;
  assign rom_we = busy;
  assign rom_addr = busy ? tbl_a[idx] : raddr;
  assign rom_wdata = busy ? tbl_d[idx] : 8'h9f;
  always @(posedge mclk) begin
    if (go) idx <= 0;
    else if (busy) idx <= idx + 1;
  end
endmodule
`default_nettype wire

// ==== testbench/spc_config_bank_tb_top.sv ====
// testbench for the config byte bank
`timescale 1ns/1ps
`default_nettype none
module switch_phy_port_config_bytes_tb_top;
  logic mclk = 0, rst = 1, go = 0, busy, rom_we, rom_re = 0, mgmt_we = 0, mgmt_re = 0;
  logic flp_req = 0, xcvr_wake, flp_start, mdix_en, lf = 0, pf = 0, pp = 0, adv, pau;
  logic rx_valid = 0, tag = 0, hi, hv, ce = 1;
  logic [7:0] raddr = 0, rom_addr, rom_wdata, rom_rdata;
  logic [4:0] maddr = 0;
  logic [15:0] mwd = 0, mrd;
  int err_count = 0, n_tests = 0, cyc = 0;
  initial forever #12.5 mclk = ~mclk;
  spc_rom_model rom (.mclk(mclk), .go(go), .raddr(raddr), .busy(busy), .rom_we(rom_we),
    .rom_addr(rom_addr), .rom_wdata(rom_wdata));
  spc_config_bank uut (.mclk(mclk), .rst(rst), .ce(ce), .rom_we(rom_we),
    .rom_addr(rom_addr), .rom_wdata(rom_wdata), .rom_re(rom_re), .rom_rdata(rom_rdata),
    .mgmt_we(mgmt_we), .mgmt_re(mgmt_re), .mgmt_addr(maddr), .mgmt_wdata(mwd),
    .mgmt_rdata(mrd), .flp_req(flp_req), .xcvr_wake(xcvr_wake), .flp_start(flp_start),
    .mdix_en(mdix_en), .link_full(lf), .partner_full(pf), .partner_pause(pp),
    .adv_full_duplex(adv), .pause_en(pau), .rx_valid(rx_valid), .rx_tag_high(tag),
    .rx_high_pri(hi), .rx_pri_valid(hv));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    raddr = a;
    rom_re = 1;
    tick;
    chk("byte", rom_rdata, e);
    rom_re = 0;
    tick;
  endtask
  task automatic mrw(logic w, logic [4:0] a, logic [15:0] d);
    maddr = a;
    mwd = d;
    mgmt_we = w;
    mgmt_re = !w;
    tick;
    mgmt_we = 0;
    mgmt_re = 0;
    tick;
  endtask
  function automatic logic exp_adv(logic dg);
    return !(dg && lf && pf && !pp);
  endfunction
  always @(posedge mclk) if (++cyc == 5000) begin
    err_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hf658));
    repeat (20) @(posedge mclk);
    #2 rst = 0;
    chk("mdix", mdix_en, 1'b1);
    rd(8'h09, 8'h03);
    rd(8'h0b, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h0d, 8'h04);
    rd(8'h08, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h0c, 8'h00);
    flp_req = 1; tick; flp_req = 0;
    for (int n = 1; n <= int'(spc_pkg::wake_lead) + 3; n++) begin
      chk("wake", xcvr_wake, n <= int'(spc_pkg::wake_lead) + 2);
      chk("flp", flp_start, n == int'(spc_pkg::wake_lead) + 2);
      tick;
    end
    go = 1; tick; go = 0;
    for (int i = 0; i < 10 && busy; i++) tick;
    rd(8'h0b, 8'h10);
    mrw(0, 5'h12, 0);
    chk("mirror dg", mrd[6], 1'b1);
    mrw(0, 5'h13, 0);
    chk("mirror pri", mrd[14:13], 2'b11);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) mrw(1, 5'h12, 16'h0000);
      {lf, pf, pp} = 3'($urandom); tick;
      chk("adv", adv, exp_adv(i < 12));
      chk("pause", pau, lf && i < 12);
    end
    for (int c = 0; c < 4; c++) begin
      mrw(1, 5'h13, {1'b0, 2'(c), 13'h0});
      rx_valid = 1;
      for (int j = 0; j < 4; j++) begin
        tag = 1'($urandom); tick;
        chk("pri vld", hv, 1'b1);
        chk("pri", hi, c[0] || (c[1] && tag));
      end
      rx_valid = 0;
    end
    rd(8'h0e, 8'h60);
    ce = 0;
    mrw(1, 5'h13, 16'h0000);
    ce = 1;
    rd(8'h0e, 8'h60);
    stop_test;
  end
endmodule
`default_nettype wire
